// *** cacc_defs.svh ***
// Constants for the counter array capture/compare block.
// Assumes byte addresses on an 8-bit APB address bus, 32-bit data.
`ifndef CACC_DEFS_SVH
`define CACC_DEFS_SVH

// ==========================================================
// Structure
`define CACC_NMOD        5
`define CACC_WDT_MOD     4

// ==========================================================
// Register byte addresses (module registers step by one word)
`define CACC_A_CMODE     8'h00
`define CACC_A_CCTRL     8'h04
`define CACC_A_CNT_LO    8'h08
`define CACC_A_CNT_HI    8'h0c
`define CACC_A_MMODE     8'h10
`define CACC_A_CMP_LO    8'h30
`define CACC_A_CMP_HI    8'h50
`define CACC_A_STEP      8'h04

// ==========================================================
// Counter mode register fields
`define CACC_CM_WATCHDOG_ENABLE_BIT     6
`define CACC_CM_SRC_HI   2
`define CACC_CM_SRC_LO   1
`define CACC_CM_OVF_IE   0
`define CACC_CM_MASK     8'h47

// ==========================================================
// Counter control register fields and module mode mask
`define CACC_CC_OVF      7
`define CACC_CC_RUN      6
`define CACC_CC_MASK     8'hdf
`define CACC_MODE_MASK   8'h7f

// ==========================================================
// Count sources and divider
`define CACC_SRC_DIV12   2'b00
`define CACC_SRC_DIV4    2'b01
`define CACC_SRC_T0      2'b10
`define CACC_SRC_EXT     2'b11
`define CACC_DIV12_LAST  4'hb
`define CACC_DIV4_LAST   2'h3

// ==========================================================
// Values
`define CACC_RST_BYTE    8'h00
`define CACC_RST_WORD    16'h0000
`define CACC_LO_WRAP     8'hff
`define CACC_CNT_MAX     16'hffff

`endif

// *** cacc_pkg.sv ***
// Types and mode decoding for the counter array capture/compare block.
// Assumes cacc_defs.svh is on the include path.
package cacc_pkg;

  // ==========================================================
  // Per-module mode byte, bit 7 reserved
  typedef struct packed {
    logic rsvd;
    logic compare_enable;
    logic capture_rise_enable;
    logic capture_fall_enable;
    logic match_flag_enable;
    logic toggle_on_match;
    logic pwm_select;
    logic module_irq_enable;
  } cacc_mode_t;

  // 16-bit value as high and low bytes
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } cacc_word_t;

  // ==========================================================
  // Mode decoding
  function automatic logic cacc_is_capture(cacc_mode_t m);
    return (m.capture_rise_enable | m.capture_fall_enable) &
           !m.match_flag_enable & !m.toggle_on_match & !m.pwm_select;
  endfunction

  function automatic logic cacc_is_compare(cacc_mode_t m);
    return m.compare_enable & m.match_flag_enable & !m.pwm_select &
           !m.capture_rise_enable & !m.capture_fall_enable;
  endfunction

  function automatic logic cacc_is_pwm(cacc_mode_t m);
    return m.compare_enable & m.pwm_select & !m.capture_rise_enable &
           !m.capture_fall_enable & !m.match_flag_enable &
           !m.toggle_on_match & !m.module_irq_enable;
  endfunction

endpackage

// *** cacc_top.sv ***
// Counter array: five capture/compare modules on one 16-bit counter.
// Assumes an APB master on pclk and module pins from outside the clock.
`timescale 1ns/1ps
`include "cacc_defs.svh"

// Functional notes
// - Rising pin edge captures counter when enabled
// - Falling pin edge captures counter when enabled
// - Both enables capture on every pin transition
// - Capture copies counter bytes into compare registers
// - Capture interrupt needs flag and module enable
// - Timer mode compares counter each count
// - Timer match interrupts with flag and enable
// - Toggle mode inverts pin on each match
// - All PWM modules share counter frequency
// - PWM pin low below compare, else high
// - Low byte wrap reloads compare low byte
// - PWM selected by pwm and compare with all other mode bits clear
// - Only module four can be watchdog
// - Watchdog match raises internal reset and sets module four flag
// - Watchdog armed by compare mode and enable
// - Clearing enable blocks reset, setting re-arms
// - Hardware sets flags, only software clears
// - Two-bit field selects counter count source
// - Counter counts only while run bit set
// - Mode register bit layout six down to zero
module cacc_top
  import cacc_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output      logic [31:0]           prdata,
  output      logic                  pready,
  output      logic                  pslverr,
  input  wire logic [`CACC_NMOD-1:0] module_pin_in,
  output      logic [`CACC_NMOD-1:0] module_pin_out,
  output      logic [`CACC_NMOD-1:0] module_pin_oe_n,
  input  wire logic                  external_count_input,
  input  wire logic                  timer0_overflow,
  output      logic                  counter_irq,
  output      logic                  watchdog_reset
);

  // ==========================================================
  // State
  logic [7:0]            counter_mode_register;
  logic [7:0]            counter_control_register;
  cacc_word_t            cnt;
  cacc_mode_t            module_mode_control [`CACC_NMOD];
  cacc_word_t            cmp                 [`CACC_NMOD];
  logic [3:0]            div;
  logic [`CACC_NMOD-1:0] pin_s1, pin_s2, pin_s3;
  logic                  eci_s1, eci_s2, eci_s3;

  logic [7:0]            next_counter_mode_register;
  logic [7:0]            next_counter_control_register;
  cacc_word_t            next_cnt;
  cacc_mode_t            next_mode           [`CACC_NMOD];
  cacc_word_t            next_cmp            [`CACC_NMOD];
  logic [3:0]            next_div;
  logic [`CACC_NMOD-1:0] next_pin_out, next_oe_n;
  logic                  next_irq, next_wdt;
  logic [31:0]           next_prdata;
  logic                  next_pready, next_pslverr;

  // Decode results and events
  logic                  access, commit, rd_hit;
  logic [7:0]            rd_byte;
  logic                  wr_cm, wr_cc, wr_cl, wr_ch;
  logic [`CACC_NMOD-1:0] wr_mode, wr_lo, wr_hi;
  logic                  src_tick, tick, ovf, wdt_armed;
  logic [15:0]           cnt_inc;
  logic [`CACC_NMOD-1:0] rise, fall, cap_ev, match_ev, flag_set, irq_en;

  // Address of a per-module register
  function automatic logic [7:0] mod_addr(logic [7:0] base, int i);
    return base + 8'(i) * `CACC_A_STEP;
  endfunction

  // ==========================================================
  // APB slave: access phase takes two cycles, commit with pready
  always_comb begin
    access       = psel & penable;
    commit       = access & pready;
    wr_cm        = commit & pwrite & (paddr == `CACC_A_CMODE);
    wr_cc        = commit & pwrite & (paddr == `CACC_A_CCTRL);
    wr_cl        = commit & pwrite & (paddr == `CACC_A_CNT_LO);
    wr_ch        = commit & pwrite & (paddr == `CACC_A_CNT_HI);
    rd_hit       = 1'b1;
    rd_byte      = `CACC_RST_BYTE;
    case (paddr)
      `CACC_A_CMODE:  rd_byte = counter_mode_register;
      `CACC_A_CCTRL:  rd_byte = counter_control_register;
      `CACC_A_CNT_LO: rd_byte = cnt.lo;
      `CACC_A_CNT_HI: rd_byte = cnt.hi;
      default:        rd_hit  = 1'b0;
    endcase
    for (int i = 0; i < `CACC_NMOD; i++) begin
      wr_mode[i] = commit & pwrite & (paddr == mod_addr(`CACC_A_MMODE, i));
      wr_lo[i]   = commit & pwrite & (paddr == mod_addr(`CACC_A_CMP_LO, i));
      wr_hi[i]   = commit & pwrite & (paddr == mod_addr(`CACC_A_CMP_HI, i));
      if (paddr == mod_addr(`CACC_A_MMODE, i)) begin
        rd_hit  = 1'b1;
        rd_byte = module_mode_control[i];
      end
      if (paddr == mod_addr(`CACC_A_CMP_LO, i)) begin
        rd_hit  = 1'b1;
        rd_byte = cmp[i].lo;
      end
      if (paddr == mod_addr(`CACC_A_CMP_HI, i)) begin
        rd_hit  = 1'b1;
        rd_byte = cmp[i].hi;
      end
    end
    next_pready  = access & !pready;
    next_pslverr = access & !pready & !rd_hit;
    next_prdata  = prdata;
    if (access & !pready) begin
      next_prdata = {24'h000000, rd_byte};
    end
  end

  // ==========================================================
  // Input synchronisers, first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      eci_s1 <= 1'b0;
      eci_s2 <= 1'b0;
      eci_s3 <= 1'b0;
    end else begin
      pin_s1 <= module_pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      eci_s1 <= external_count_input;
      eci_s2 <= eci_s1;
      eci_s3 <= eci_s2;
    end
  end

  // ==========================================================
  // Count source, shared counter and control registers
  always_comb begin
    next_div = (div == `CACC_DIV12_LAST) ? 4'h0 : div + 4'h1;
    case (counter_mode_register[`CACC_CM_SRC_HI:`CACC_CM_SRC_LO])
      `CACC_SRC_DIV12: src_tick = (div == `CACC_DIV12_LAST);
      `CACC_SRC_DIV4:  src_tick = (div[1:0] == `CACC_DIV4_LAST);
      `CACC_SRC_T0:    src_tick = timer0_overflow;
      `CACC_SRC_EXT:   src_tick = eci_s2 & !eci_s3;
      default:         src_tick = 1'b0;
    endcase
    tick    = counter_control_register[`CACC_CC_RUN] & src_tick;
    cnt_inc = cnt + 16'h0001;
    ovf     = tick & (cnt == `CACC_CNT_MAX);
    next_cnt = cnt;
    if (tick) begin
      next_cnt = cnt_inc;
    end
    if (wr_cl) begin
      next_cnt.lo = pwdata[7:0];
    end
    if (wr_ch) begin
      next_cnt.hi = pwdata[7:0];
    end
    next_counter_mode_register = counter_mode_register;
    if (wr_cm) begin
      next_counter_mode_register = pwdata[7:0] & `CACC_CM_MASK;
    end
    // Software write may clear flags; hardware set wins
    next_counter_control_register = counter_control_register;
    if (wr_cc) begin
      next_counter_control_register = pwdata[7:0] & `CACC_CC_MASK;
    end
    next_counter_control_register[`CACC_NMOD-1:0] =
      next_counter_control_register[`CACC_NMOD-1:0] | flag_set;
    if (ovf) begin
      next_counter_control_register[`CACC_CC_OVF] = 1'b1;
    end
  end

  // ==========================================================
  // Capture/compare modules
  always_comb begin
    rise         = pin_s2 & ~pin_s3;
    fall         = ~pin_s2 & pin_s3;
    next_pin_out = module_pin_out;
    next_oe_n    = module_pin_oe_n;
    for (int i = 0; i < `CACC_NMOD; i++) begin
      next_mode[i] = module_mode_control[i];
      if (wr_mode[i]) begin
        next_mode[i] = cacc_mode_t'(pwdata[7:0] & `CACC_MODE_MASK);
      end
      // Capture on selected edges
      cap_ev[i] = cacc_is_capture(module_mode_control[i]) &
        ((module_mode_control[i].capture_rise_enable & rise[i]) |
         (module_mode_control[i].capture_fall_enable & fall[i]));
      // Match on the count that reaches the compare value
      match_ev[i] = cacc_is_compare(module_mode_control[i]) & tick &
                    (cnt_inc == cmp[i]);
      flag_set[i] = cap_ev[i] | match_ev[i];
      irq_en[i]   = module_mode_control[i].module_irq_enable;
      next_cmp[i] = cmp[i];
      if (wr_lo[i]) begin
        next_cmp[i].lo = pwdata[7:0];
      end
      if (wr_hi[i]) begin
        next_cmp[i].hi = pwdata[7:0];
      end
      // Glitch-free duty update at low byte wrap
      if (cacc_is_pwm(module_mode_control[i]) && tick &&
          cnt.lo == `CACC_LO_WRAP) begin
        next_cmp[i].lo = cmp[i].hi;
      end
      if (cap_ev[i]) begin
        next_cmp[i] = cnt;
      end
      // Pin drive: toggle on match, or PWM level
      if (cacc_is_compare(module_mode_control[i]) &&
          module_mode_control[i].toggle_on_match) begin
        next_oe_n[i] = 1'b0;
        if (match_ev[i]) begin
          next_pin_out[i] = !module_pin_out[i];
        end
      end else if (cacc_is_pwm(module_mode_control[i])) begin
        next_oe_n[i]    = 1'b0;
        next_pin_out[i] = (cnt.lo >= cmp[i].lo);
      end else begin
        next_oe_n[i] = 1'b1;
      end
    end
    // Interrupt request from flags gated by enables
    next_irq = (counter_control_register[`CACC_CC_OVF] &
                counter_mode_register[`CACC_CM_OVF_IE]) |
               (|(counter_control_register[`CACC_NMOD-1:0] & irq_en));
    // Watchdog on module four only
    wdt_armed = counter_mode_register[`CACC_CM_WATCHDOG_ENABLE_BIT] &
                cacc_is_compare(module_mode_control[`CACC_WDT_MOD]);
    next_wdt  = wdt_armed & match_ev[`CACC_WDT_MOD];
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_mode_register    <= `CACC_RST_BYTE;
      counter_control_register <= `CACC_RST_BYTE;
      cnt                      <= `CACC_RST_WORD;
      div                      <= 4'h0;
      for (int i = 0; i < `CACC_NMOD; i++) begin
        module_mode_control[i] <= cacc_mode_t'(`CACC_RST_BYTE);
        cmp[i]                 <= `CACC_RST_WORD;
      end
      module_pin_out  <= '0;
      module_pin_oe_n <= '1;
      counter_irq     <= 1'b0;
      watchdog_reset  <= 1'b0;
      prdata          <= 32'h00000000;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
    end else begin
      counter_mode_register    <= next_counter_mode_register;
      counter_control_register <= next_counter_control_register;
      cnt                      <= next_cnt;
      div                      <= next_div;
      module_mode_control      <= next_mode;
      cmp                      <= next_cmp;
      module_pin_out           <= next_pin_out;
      module_pin_oe_n          <= next_oe_n;
      counter_irq              <= next_irq;
      watchdog_reset           <= next_wdt;
      prdata                   <= next_prdata;
      pready                   <= next_pready;
      pslverr                  <= next_pslverr;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  cap_load_a: assert property (cap_ev[0] |=> cmp[0] == $past(cnt))
    else $error("capture did not load counter");
  cap_flag_a: assert property (cap_ev[1] |=> counter_control_register[1])
    else $error("capture did not set flag");
  flag_hold_a: assert property (
    counter_control_register[0] && !wr_cc |=> counter_control_register[0]
  ) else $error("flag cleared without write");
  irq_req_a: assert property (
    counter_control_register[2] && module_mode_control[2].module_irq_enable
    |=> counter_irq
  ) else $error("missing interrupt request");
  hso_toggle_a: assert property (
    match_ev[3] && module_mode_control[3].toggle_on_match
    |=> module_pin_out[3] != $past(module_pin_out[3])
  ) else $error("pin did not toggle on match");
  pwm_level_a: assert property (
    cacc_is_pwm(module_mode_control[2]) ##1 cacc_is_pwm(module_mode_control[2])
    |-> module_pin_out[2] == ($past(cnt.lo) >= $past(cmp[2].lo))
  ) else $error("pwm level wrong");
  pwm_reload_a: assert property (
    cacc_is_pwm(module_mode_control[2]) && tick && cnt.lo == 8'hff &&
    !cap_ev[2] |=> cmp[2].lo == $past(cmp[2].hi)
  ) else $error("pwm low byte not reloaded");
  wdt_fire_a: assert property (
    wdt_armed && match_ev[4] |=> watchdog_reset ##1 !watchdog_reset
  ) else $error("watchdog reset not pulsed");
  wdt_off_a: assert property (
    !counter_mode_register[6] |=> !watchdog_reset
  ) else $error("watchdog fired while disabled");
  run_hold_a: assert property (
    !counter_control_register[6] && !wr_cl && !wr_ch |=> $stable(cnt)
  ) else $error("counter moved while stopped");
  apb_ready_a: assert property (
    access && !pready |=> pready ##1 !pready
  ) else $error("apb answer not one cycle");

endmodule

// *** cacc_pin_model.sv ***
// Pin-side model: five module pins and the external count pin.
// Assumes the block drives a pin while its output enable is low.
`timescale 1ns/1ps
module cacc_pin_model (
  input  wire logic       pclk,
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe_n,
  output      logic [4:0] pin_in,
  output      logic       ext_in
);
  logic [4:0] lvl;

  // ==========================================================
  // Levels
  // Start quiet so no edge is seen out of reset
  initial begin
    lvl = 5'h00;
    ext_in = 1'b0;
  end

  // A driven pin reads back the block's own level
  always_comb pin_in = (pin_out & ~pin_oe_n) | (lvl & pin_oe_n);

  // ==========================================================
  // Commands
  // Change one pin level just after a clock edge
  task automatic set_pin(input logic [2:0] i, input logic v);
    @(posedge pclk);
    lvl[i] <= v;
  endtask

  // One slow count pulse, long enough to pass the synchroniser
  task automatic ext_pulse();
    @(posedge pclk);
    ext_in <= 1'b1;
    repeat (4) @(posedge pclk);
    ext_in <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// *** counter_array_capture_compare_tb.sv ***
// Self-checking bench for the counter array capture/compare block.
// Assumes cacc_defs.svh on the include path and the pin model file.
`timescale 1ns/1ps
`include "cacc_defs.svh"
module counter_array_capture_compare_tb;
  logic        pclk, presetn, psel, penable, pwrite, t0_ovf;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, counter_irq, watchdog_reset, ext_in;
  logic [4:0]  pin_in, pin_out, pin_oe_n;
  int          n_errors, total_checks, wd_count, wd0;

  // ==========================================================
  // Instances
  cacc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .module_pin_in(pin_in), .module_pin_out(pin_out),
    .module_pin_oe_n(pin_oe_n), .external_count_input(ext_in),
    .timer0_overflow(t0_ovf), .counter_irq(counter_irq),
    .watchdog_reset(watchdog_reset));
  cacc_pin_model pins (.pclk(pclk), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_in(pin_in), .ext_in(ext_in));

  // Clock at 40 MHz
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Count internal reset pulses
  always @(posedge pclk) begin
    if (watchdog_reset === 1'b1) wd_count++;
  end

  // ==========================================================
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready, then releases
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check(rd, {24'h000000, e});
  endtask

  task automatic setcnt(input logic [15:0] v);
    wr(`CACC_A_CNT_LO, v[7:0]);
    wr(`CACC_A_CNT_HI, v[15:8]);
  endtask

  // Low byte first, as software must
  task automatic setcmp(input logic [2:0] m, input logic [15:0] v);
    wr(`CACC_A_CMP_LO + {3'b000, m, 2'b00}, v[7:0]);
    wr(`CACC_A_CMP_HI + {3'b000, m, 2'b00}, v[15:8]);
  endtask

  // Timer 0 overflow pulses, one count each
  task automatic t0(input int n);
    repeat (n) begin
      @(posedge pclk);
      t0_ovf <= 1'b1;
      @(posedge pclk);
      t0_ovf <= 1'b0;
    end
    repeat (2) @(posedge pclk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic s_regs();
    rdchk(`CACC_A_CMODE, 8'h00);
    rdchk(`CACC_A_CCTRL, 8'h00);
    wr(`CACC_A_MMODE, 8'hff);
    rdchk(`CACC_A_MMODE, 8'h7f);
    wr(`CACC_A_MMODE, 8'h00);
    apb(1'b0, 8'hfc, 8'h00);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
  endtask

  task automatic s_source();
    setcnt(16'hfffe);
    wr(`CACC_A_CMODE, 8'h04);
    t0(3);
    rdchk(`CACC_A_CNT_LO, 8'hfe);
    wr(`CACC_A_CCTRL, 8'h40);
    t0(5);
    // Stop the counter but keep the overflow flag set
    wr(`CACC_A_CCTRL, 8'h80);
    rdchk(`CACC_A_CNT_LO, 8'h03);
    rdchk(`CACC_A_CNT_HI, 8'h00);
    rdchk(`CACC_A_CCTRL, 8'h80);
    wr(`CACC_A_CCTRL, 8'h00);
    rdchk(`CACC_A_CCTRL, 8'h00);
    setcnt(16'h0000);
    wr(`CACC_A_CMODE, 8'h06);
    wr(`CACC_A_CCTRL, 8'h40);
    repeat (3) pins.ext_pulse();
    wr(`CACC_A_CCTRL, 8'h00);
    rdchk(`CACC_A_CNT_LO, 8'h03);
    // Divided clock sources, about 124 clocks of run each
    for (int s = 0; s < 2; s++) begin
      setcnt(16'h0000);
      wr(`CACC_A_CMODE, s ? 8'h00 : 8'h02);
      wr(`CACC_A_CCTRL, 8'h40);
      repeat (120) @(posedge pclk);
      wr(`CACC_A_CCTRL, 8'h00);
      apb(1'b0, `CACC_A_CNT_LO, 8'h00);
      check({31'h0, s ? (rd >= 9 && rd <= 12) : (rd >= 29 && rd <= 33)},
            32'h1);
    end
  endtask

  // Capture on one module: pre-level, arm, edge, judge
  task automatic cap(input logic [2:0] m, input logic [7:0] mode,
                     input logic rise, input logic hit);
    logic [7:0] ma;
    ma = `CACC_A_MMODE + {3'b000, m, 2'b00};
    wr(ma, 8'h00);
    pins.set_pin(m, ~rise);
    repeat (6) @(posedge pclk);
    setcmp(m, 16'h0000);
    setcnt(16'h1234 + m);
    wr(ma, mode);
    pins.set_pin(m, rise);
    repeat (6) @(posedge pclk);
    rdchk(`CACC_A_CMP_LO + {3'b000, m, 2'b00}, hit ? 8'h34 + m : 8'h00);
    rdchk(`CACC_A_CMP_HI + {3'b000, m, 2'b00}, hit ? 8'h12 : 8'h00);
    rdchk(`CACC_A_CCTRL, hit ? 8'h01 << m : 8'h00);
    check({31'h0, counter_irq}, {31'h0, hit & mode[0]});
    wr(`CACC_A_CCTRL, 8'h00);
    repeat (6) @(posedge pclk);
    rdchk(`CACC_A_CCTRL, 8'h00);
    check({31'h0, counter_irq}, 32'h0);
    wr(ma, 8'h00);
  endtask

  task automatic s_capture();
    cap(3'd0, 8'h21, 1'b1, 1'b1);
    cap(3'd0, 8'h21, 1'b0, 1'b0);
    cap(3'd1, 8'h11, 1'b0, 1'b1);
    cap(3'd1, 8'h11, 1'b1, 1'b0);
    cap(3'd2, 8'h31, 1'b1, 1'b1);
    cap(3'd2, 8'h31, 1'b0, 1'b1);
    cap(3'd3, 8'h20, 1'b1, 1'b1);
    cap(3'd4, 8'h00, 1'b1, 1'b0);
  endtask

  task automatic s_timer();
    setcnt(16'h0000);
    setcmp(3'd1, 16'h0010);
    wr(`CACC_A_CMODE, 8'h04);
    wr(`CACC_A_MMODE + 8'h04, 8'h4d);
    wr(`CACC_A_CCTRL, 8'h40);
    t0(15);
    check({31'h0, pin_out[1]}, 32'h0);
    rdchk(`CACC_A_CCTRL, 8'h40);
    t0(1);
    check({31'h0, pin_out[1]}, 32'h1);
    check({31'h0, pin_oe_n[1]}, 32'h0);
    rdchk(`CACC_A_CCTRL, 8'h42);
    check({31'h0, counter_irq}, 32'h1);
    wr(`CACC_A_CCTRL, 8'h00);
    wr(`CACC_A_MMODE + 8'h04, 8'h00);
  endtask

  // Module 3 matches too but must never reset; compare moved from main line
  task automatic s_wdog();
    setcmp(3'd4, 16'h0005);
    setcmp(3'd3, 16'h0005);
    wr(`CACC_A_MMODE + 8'h0c, 8'h4c);
    wr(`CACC_A_MMODE + 8'h10, 8'h48);
    wd0 = wd_count;
    for (int p = 0; p < 3; p++) begin
      wr(`CACC_A_CMODE, p == 1 ? 8'h04 : 8'h44);
      setcnt(16'h0000);
      wr(`CACC_A_CCTRL, 8'h40);
      t0(5);
      wr(`CACC_A_CCTRL, 8'h00);
      check(32'(wd_count - wd0), p == 2 ? 32'h2 : 32'h1);
    end
    // Module 3 toggled on each of its three matches
    check({31'h0, pin_out[3]}, 32'h1);
    check({31'h0, pin_oe_n[4]}, 32'h1);
    wr(`CACC_A_MMODE + 8'h0c, 8'h00);
    wr(`CACC_A_MMODE + 8'h10, 8'h00);
    wr(`CACC_A_CCTRL, 8'h00);
  endtask

  task automatic s_pwm();
    wr(`CACC_A_CMODE, 8'h04);
    setcmp(3'd2, 16'h4080);
    wr(`CACC_A_MMODE + 8'h08, 8'h42);
    setcnt(16'h007f);
    repeat (3) @(posedge pclk);
    check({31'h0, pin_out[2]}, 32'h0);
    check({31'h0, pin_oe_n[2]}, 32'h0);
    setcnt(16'h0080);
    repeat (3) @(posedge pclk);
    check({31'h0, pin_out[2]}, 32'h1);
    setcnt(16'h00ff);
    wr(`CACC_A_CCTRL, 8'h40);
    t0(1);
    wr(`CACC_A_CCTRL, 8'h00);
    rdchk(`CACC_A_CMP_LO + 8'h08, 8'h40);
    check({31'h0, pin_out[2]}, 32'h0);
    wr(`CACC_A_MMODE + 8'h08, 8'h43);
    repeat (3) @(posedge pclk);
    check({31'h0, pin_oe_n[2]}, 32'h1);
    wr(`CACC_A_MMODE + 8'h08, 8'h00);
  endtask

  // ==========================================================
  // Verdict and run control
  task automatic conclude();
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, far beyond the roughly 1300 clocks the run needs
  initial begin
    #2000000;
    n_errors++;
    conclude();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    t0_ovf = 1'b0;
    n_errors = 0;
    total_checks = 0;
    wd_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_source();
    s_capture();
    s_timer();
    s_wdog();
    s_pwm();
    conclude();
  end
endmodule
